// *** ipvs_params.svh ***
// constants for the interrupt priority and vector status block
`ifndef IPVS_PARAMS_SVH
`define IPVS_PARAMS_SVH

// register byte offsets
`define IPVS_OFS_PRIO18 8'h00
`define IPVS_OFS_PRIO19 8'h04
`define IPVS_OFS_PRIO20 8'h08
`define IPVS_OFS_PRIO21 8'h0c
`define IPVS_OFS_PRIO22 8'h10
`define IPVS_OFS_PRIO23 8'h14
`define IPVS_OFS_STATUS 8'h18
`define IPVS_OFS_EVT_STAT 8'h1c
`define IPVS_OFS_EVT_CLR 8'h20
`define IPVS_OFS_EVT_EN 8'h24
`define IPVS_NUM_PRIO_REGS 6
`define IPVS_NUM_WORDS 10

// per source: field lsb position, as priority register index * 16 + lsb
`define IPVS_FIELD_MAP {8'h50, 8'h54, 8'h40, 8'h44, 8'h48, 8'h4c, 8'h30, \
                        8'h34, 8'h3c, 8'h24, 8'h28, 8'h2c, 8'h14, 8'h00}
`define IPVS_NUM_SRC 14

// field widths, positions and reset values
`define IPVS_PRIO_W 3
`define IPVS_PRIO_RESET 3'h4
`define IPVS_PRIO_OFF 3'h0
`define IPVS_LEVEL_W 4
`define IPVS_VEC_W 7
`define IPVS_VEC_BASE_DEFAULT 7'h00
`define IPVS_BIT_PEND 15
`define IPVS_BIT_VECTOR_CAPTURE_SELECT 13
`define IPVS_LEVEL_LSB 8
`define IPVS_VEC_LSB 0

// event bits
`define IPVS_EVT_W 3
`define IPVS_EVT_ACK 0
`define IPVS_EVT_BLOCKED 1
`define IPVS_EVT_TRAP 2

`define IPVS_HSIZE_WORD 3'h2
`define IPVS_HRESP_OKAY 1'b0

`endif

// *** ipvs_pkg.sv ***
// types shared by the interrupt priority and vector status block
package ipvs_pkg;

  typedef enum logic [3:0] {
    IPVS_BUS_IDLE = 4'h1,
    IPVS_BUS_WR = 4'h2,
    IPVS_BUS_RD_WAIT = 4'h4,
    IPVS_BUS_RD_DATA = 4'h8
  } ipvs_bus_state_t;

endpackage : ipvs_pkg

// *** ipvs_arbiter.sv ***
// picks the highest priority enabled pending source
`timescale 1ns/1ps
`include "ipvs_params.svh"

module ipvs_arbiter #(
  parameter int NUM_SRC = `IPVS_NUM_SRC,
  parameter int IDX_W = 4
) (
  input wire logic [NUM_SRC*`IPVS_PRIO_W-1:0] prio_flat,
  input wire logic [NUM_SRC-1:0] pend,
  output logic best_valid,
  output logic [`IPVS_PRIO_W-1:0] best_prio,
  output logic [IDX_W-1:0] best_idx
);

  initial begin
    if (NUM_SRC < 1 || NUM_SRC > (1 << IDX_W)) begin
      $error("ipvs_arbiter: index width too small for source count");
    end
  end

  always_comb begin
    logic [`IPVS_PRIO_W-1:0] p;
    p = `IPVS_PRIO_OFF;
    best_valid = 1'b0;
    best_prio = `IPVS_PRIO_OFF;
    best_idx = '0;
    // scan downward with >= so the lowest index, i.e. lowest vector, wins ties
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      p = prio_flat[i*`IPVS_PRIO_W +: `IPVS_PRIO_W];
      if (pend[i] && p != `IPVS_PRIO_OFF && p >= best_prio) begin
        best_valid = 1'b1;
        best_prio = p;
        best_idx = IDX_W'(i);
      end
    end
  end

endmodule : ipvs_arbiter

// *** ipvs_top.sv ***
// priority registers, request arbitration and vector status with AHB-Lite access
`timescale 1ns/1ps
`include "ipvs_params.svh"

module ipvs_top #(
  parameter int NUM_SRC = `IPVS_NUM_SRC,
  parameter int ADDR_W = 32,
  // arbitrary default; the real vector map of the sources is set at integration
  parameter logic [`IPVS_VEC_W-1:0] VEC_BASE = `IPVS_VEC_BASE_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [NUM_SRC-1:0] src_pending,
  input wire logic trap_req,
  input wire logic [2:0] trap_code,
  input wire logic [`IPVS_LEVEL_W-1:0] cpu_level,
  input wire logic cpu_ack,
  output logic cpu_irq_req,
  output logic [`IPVS_LEVEL_W-1:0] cpu_irq_level,
  output logic [`IPVS_VEC_W-1:0] cpu_irq_vector,
  output logic cpu_irq_is_trap,
  output logic irq
);

  localparam logic [8*`IPVS_NUM_SRC-1:0] FIELD_MAP = `IPVS_FIELD_MAP;
  localparam int IMG_W = 16 * `IPVS_NUM_PRIO_REGS;

  initial begin
    if (NUM_SRC != `IPVS_NUM_SRC) begin
      $error("ipvs_top: source count is fixed by the register layout");
    end
    if (ADDR_W < 8) begin
      $error("ipvs_top: address too narrow for the register map");
    end
    if (int'(VEC_BASE) + NUM_SRC > 128) begin
      $error("ipvs_top: vector ids do not fit the seven bit field");
    end
  end

  // ---------------- bus slave ----------------
  ipvs_pkg::ipvs_bus_state_t bus_state_reg;
  ipvs_pkg::ipvs_bus_state_t bus_state_next;
  logic [3:0] dp_word_reg;
  logic dp_mapped_reg;
  logic dp_word_ok_reg;
  logic [31:0] hrdata_reg;
  logic accept;
  logic addr_mapped;
  logic wr_en;

  // registers
  logic [`IPVS_PRIO_W-1:0] prio_reg [NUM_SRC];
  logic vector_capture_select_reg;
  logic [`IPVS_EVT_W-1:0] evt_stat_reg;
  logic [`IPVS_EVT_W-1:0] evt_en_reg;
  logic [`IPVS_EVT_W-1:0] evt_set;
  logic [`IPVS_EVT_W-1:0] evt_clr;
  logic [IMG_W-1:0] prio_image;
  logic [NUM_SRC*`IPVS_PRIO_W-1:0] prio_flat;
  logic [31:0] rd_word;

  // arbitration and request path
  logic best_valid;
  logic [`IPVS_PRIO_W-1:0] best_prio;
  logic [3:0] best_idx;
  logic best_above;
  logic [`IPVS_VEC_W-1:0] best_vec;
  logic req_reg;
  logic [`IPVS_LEVEL_W-1:0] req_level_reg;
  logic [`IPVS_VEC_W-1:0] req_vec_reg;
  logic req_trap_reg;
  logic ack_take;
  logic [`IPVS_LEVEL_W-1:0] new_level_reg;
  logic [`IPVS_VEC_W-1:0] ack_vec_reg;
  logic [`IPVS_VEC_W-1:0] live_vec_reg;
  logic pend_flag_reg;
  logic pend_flag_next;

  assign accept = hsel && htrans[1] && hready;
  assign addr_mapped = (haddr[ADDR_W-1:2] < (ADDR_W-2)'(`IPVS_NUM_WORDS)) && (haddr[1:0] == 2'h0);
  assign wr_en = (bus_state_reg == ipvs_pkg::IPVS_BUS_WR) && dp_mapped_reg && dp_word_ok_reg;

  always_comb begin
    bus_state_next = ipvs_pkg::IPVS_BUS_IDLE;
    case (bus_state_reg)
      ipvs_pkg::IPVS_BUS_RD_WAIT: begin
        bus_state_next = ipvs_pkg::IPVS_BUS_RD_DATA;
      end
      ipvs_pkg::IPVS_BUS_IDLE, ipvs_pkg::IPVS_BUS_WR, ipvs_pkg::IPVS_BUS_RD_DATA: begin
        if (accept) begin
          bus_state_next = hwrite ? ipvs_pkg::IPVS_BUS_WR : ipvs_pkg::IPVS_BUS_RD_WAIT;
        end
      end
      default: begin
        bus_state_next = ipvs_pkg::IPVS_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_state_reg <= ipvs_pkg::IPVS_BUS_IDLE;
      dp_word_reg <= 4'h0;
      dp_mapped_reg <= 1'b0;
      dp_word_ok_reg <= 1'b0;
    end else begin
      bus_state_reg <= bus_state_next;
      if (accept && bus_state_reg != ipvs_pkg::IPVS_BUS_RD_WAIT) begin
        dp_word_reg <= haddr[5:2];
        dp_mapped_reg <= addr_mapped;
        dp_word_ok_reg <= (hsize == `IPVS_HSIZE_WORD);
      end
    end
  end

  // one wait state on reads so a read right after a write sees the new value
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata_reg <= 32'h0;
    end else if (bus_state_reg == ipvs_pkg::IPVS_BUS_RD_WAIT) begin
      hrdata_reg <= dp_mapped_reg ? rd_word : 32'h0;
    end
  end

  assign hreadyout = (bus_state_reg != ipvs_pkg::IPVS_BUS_RD_WAIT);
  assign hrdata = hrdata_reg;
  assign hresp = `IPVS_HRESP_OKAY;

  // ---------------- priority fields ----------------
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
    localparam int POS = int'(FIELD_MAP[s*8 +: 8]);
    localparam logic [3:0] WORD = 4'(POS / 16);
    localparam int LSB = POS % 16;
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        prio_reg[s] <= `IPVS_PRIO_RESET;
      end else if (wr_en && dp_word_reg == WORD) begin
        prio_reg[s] <= hwdata[LSB +: `IPVS_PRIO_W];
      end
    end
    assign prio_flat[s*`IPVS_PRIO_W +: `IPVS_PRIO_W] = prio_reg[s];
  end

  always_comb begin
    prio_image = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      // each source's field at its mapped position in its register
      prio_image[int'(FIELD_MAP[s*8 +: 8]) +: `IPVS_PRIO_W] = prio_reg[s];
    end
  end

  // ---------------- status, events and read mux ----------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vector_capture_select_reg <= 1'b0;
    end else if (wr_en && {dp_word_reg, 2'h0} == 6'(`IPVS_OFS_STATUS)) begin
      vector_capture_select_reg <= hwdata[`IPVS_BIT_VECTOR_CAPTURE_SELECT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      evt_en_reg <= '0;
    end else if (wr_en && {dp_word_reg, 2'h0} == 6'(`IPVS_OFS_EVT_EN)) begin
      evt_en_reg <= hwdata[`IPVS_EVT_W-1:0];
    end
  end

  assign evt_clr = (wr_en && {dp_word_reg, 2'h0} == 6'(`IPVS_OFS_EVT_CLR)) ?
                   hwdata[`IPVS_EVT_W-1:0] : '0;

  always_comb begin
    evt_set = '0;
    evt_set[`IPVS_EVT_ACK] = ack_take && !req_trap_reg;
    evt_set[`IPVS_EVT_BLOCKED] = pend_flag_next && !pend_flag_reg;
    evt_set[`IPVS_EVT_TRAP] = ack_take && req_trap_reg;
  end

  // a set in the same cycle as its clear wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      evt_stat_reg <= '0;
    end else begin
      evt_stat_reg <= (evt_stat_reg & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((evt_stat_reg & ~evt_clr) | evt_set) & evt_en_reg);
    end
  end

  always_comb begin
    rd_word = 32'h0;
    if (dp_word_reg < 4'(`IPVS_NUM_PRIO_REGS)) begin
      rd_word[15:0] = prio_image[dp_word_reg*16 +: 16];
    end else begin
      case ({dp_word_reg, 2'h0})
        6'(`IPVS_OFS_STATUS): begin
          rd_word[`IPVS_BIT_PEND] = pend_flag_reg;
          rd_word[`IPVS_BIT_VECTOR_CAPTURE_SELECT] = vector_capture_select_reg;
          rd_word[`IPVS_LEVEL_LSB +: `IPVS_LEVEL_W] = new_level_reg;
          rd_word[`IPVS_VEC_LSB +: `IPVS_VEC_W] = vector_capture_select_reg ? live_vec_reg : ack_vec_reg;
        end
        6'(`IPVS_OFS_EVT_STAT): begin
          rd_word[`IPVS_EVT_W-1:0] = evt_stat_reg;
        end
        6'(`IPVS_OFS_EVT_EN): begin
          rd_word[`IPVS_EVT_W-1:0] = evt_en_reg;
        end
        default: begin
          rd_word = 32'h0;
        end
      endcase
    end
  end

  // ---------------- arbitration and cpu request ----------------
  ipvs_arbiter #(
    .NUM_SRC(NUM_SRC),
    .IDX_W(4)
  ) u_arbiter (
    .prio_flat(prio_flat),
    .pend(src_pending),
    .best_valid(best_valid),
    .best_prio(best_prio),
    .best_idx(best_idx)
  );

  // field value is the level itself
  assign best_above = best_valid && ({1'b0, best_prio} > cpu_level);
  assign best_vec = VEC_BASE + `IPVS_VEC_W'(best_idx);
  assign pend_flag_next = best_valid && !best_above;
  assign ack_take = cpu_ack && req_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_reg <= 1'b0;
      req_level_reg <= 4'h0;
      req_vec_reg <= 7'h00;
      req_trap_reg <= 1'b0;
    end else if (trap_req) begin
      // traps bypass the cpu level and priority fields
      // an acknowledged trap drops for one cycle and comes back while still held
      req_reg <= !ack_take;
      req_level_reg <= {1'b1, trap_code};
      req_trap_reg <= 1'b1;
    end else begin
      // forward only when above the cpu level
      req_reg <= best_above && !ack_take;
      req_level_reg <= {1'b0, best_prio};
      req_vec_reg <= best_vec;
      req_trap_reg <= 1'b0;
    end
  end

  assign cpu_irq_req = req_reg;
  assign cpu_irq_level = req_level_reg;
  assign cpu_irq_vector = req_vec_reg;
  assign cpu_irq_is_trap = req_trap_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      new_level_reg <= 4'h0;
      ack_vec_reg <= 7'h00;
    end else if (ack_take) begin
      new_level_reg <= req_level_reg;
      // trap vectors lie below the field's range, so it keeps the last user vector
      if (!req_trap_reg) begin
        ack_vec_reg <= req_vec_reg;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      live_vec_reg <= 7'h00;
      pend_flag_reg <= 1'b0;
    end else begin
      if (best_valid) begin
        live_vec_reg <= best_vec;
      end
      pend_flag_reg <= pend_flag_next;
    end
  end

endmodule : ipvs_top

// *** ipvs_checker.sv ***
// assertion checker on the ports of the priority and vector status block
`timescale 1ns/1ps
`include "ipvs_params.svh"
module ipvs_checker #(
  parameter int NUM_SRC = 14,
  parameter logic [6:0] VEC_BASE = 7'h00
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [NUM_SRC-1:0] src_pending,
  input wire logic trap_req,
  input wire logic [2:0] trap_code,
  input wire logic [3:0] cpu_level,
  input wire logic cpu_ack,
  input wire logic cpu_irq_req,
  input wire logic [3:0] cpu_irq_level,
  input wire logic [6:0] cpu_irq_vector,
  input wire logic cpu_irq_is_trap
);
  logic take;
  assign take = hsel && htrans[1] && hready;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_resp_okay:
    assert property (hresp == `IPVS_HRESP_OKAY) else $error("bus response not okay");
  a_write_no_wait:
    assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  a_read_one_wait:
    assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait");
  a_upper_zero:
    assert property (hrdata[31:16] == 16'h0000) else $error("upper read bits set");
  a_trap_wins:
    assert property (trap_req && !cpu_ack |=> cpu_irq_req && cpu_irq_is_trap
      && cpu_irq_level == 4'h8 + {1'b0, $past(trap_code)}) else $error("trap not sent");
  a_user_level:
    assert property (cpu_irq_req && !cpu_irq_is_trap |-> cpu_irq_level > $past(cpu_level)
      && cpu_irq_level <= 4'h7) else $error("user level wrong");
  a_user_source:
    assert property (cpu_irq_req && !cpu_irq_is_trap
      |-> (($past(src_pending) >> (cpu_irq_vector - VEC_BASE)) & 1) != 0)
      else $error("vector not pending");
  a_ack_clears:
    assert property (cpu_ack && cpu_irq_req |=> !cpu_irq_req) else $error("ack ignored");
  a_idle_quiet:
    assert property (!trap_req && src_pending == '0 |=> !cpu_irq_req)
      else $error("request from nothing");
endmodule : ipvs_checker

bind ipvs_top ipvs_checker #(.NUM_SRC(NUM_SRC), .VEC_BASE(VEC_BASE)) ipvs_checker_i (
  .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .src_pending(src_pending), .trap_req(trap_req), .trap_code(trap_code),
  .cpu_level(cpu_level), .cpu_ack(cpu_ack), .cpu_irq_req(cpu_irq_req),
  .cpu_irq_level(cpu_irq_level), .cpu_irq_vector(cpu_irq_vector),
  .cpu_irq_is_trap(cpu_irq_is_trap)
);

// *** ipvs_cpu_model.sv ***
// processor core model that takes interrupt requests
`timescale 1ns/1ps
module ipvs_cpu_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cpu_irq_req,
  input wire logic ack_en,
  input wire logic [3:0] ack_wait,
  output logic cpu_ack
);
  logic [3:0] wait_reg;
  // a slow core lets the request stand ack_wait + 1 cycles before taking it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wait_reg <= 4'h0;
      cpu_ack <= 1'b0;
    end else if (ack_en && cpu_irq_req && !cpu_ack) begin
      cpu_ack <= (wait_reg == ack_wait);
      wait_reg <= (wait_reg == ack_wait) ? 4'h0 : wait_reg + 4'h1;
    end else begin
      cpu_ack <= 1'b0;
      wait_reg <= 4'h0;
    end
  end
endmodule : ipvs_cpu_model

// *** ipvs_top_tb.sv ***
// self-checking testbench for the priority and vector status block
`timescale 1ns/1ps
`include "ipvs_params.svh"
module ipvs_top_tb;
  localparam logic [111:0] FMAP = `IPVS_FIELD_MAP;
  logic ref_clk, rst, hsel, hwrite, hreadyout, hresp, trap_req, cpu_ack, ack_en;
  logic cpu_irq_req, cpu_irq_is_trap, irq;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize, trap_code;
  logic [13:0] src_pending;
  logic [3:0] cpu_level, cpu_irq_level, ack_wait;
  logic [6:0] cpu_irq_vector;
  logic [15:0] shadow [6];
  logic [15:0] mask [6];
  logic [15:0] rstv [6];
  int errors, compares;

  ipvs_top ipvs_top_i (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .src_pending(src_pending),
    .trap_req(trap_req), .trap_code(trap_code), .cpu_level(cpu_level), .cpu_ack(cpu_ack),
    .cpu_irq_req(cpu_irq_req), .cpu_irq_level(cpu_irq_level),
    .cpu_irq_vector(cpu_irq_vector), .cpu_irq_is_trap(cpu_irq_is_trap), .irq(irq)
  );
  ipvs_cpu_model ipvs_cpu_model_i (
    .ref_clk(ref_clk), .rst(rst), .cpu_irq_req(cpu_irq_req), .ack_en(ack_en),
    .ack_wait(ack_wait), .cpu_ack(cpu_ack)
  );

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic finish_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // wait for hreadyout or the model's cpu_ack to go high, giving up after 51 edges
  task automatic wait_hi(input int sel);
    int n;
    n = 0;
    @(posedge ref_clk);
    while ((sel == 0 ? hreadyout : cpu_ack) !== 1'b1) begin
      n++;
      if (n > 50) begin
        errors++;
        finish_test;
      end
      @(posedge ref_clk);
    end
  endtask : wait_hi

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= `IPVS_HSIZE_WORD;
    haddr <= {24'h0, a};
    wait_hi(0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_hi(0);
    rdv = hrdata;
  endtask : bus

  task automatic setp(input int s, input logic [2:0] p);
    int f;
    f = FMAP[8*s +: 8];
    shadow[f/16][f%16 +: 3] = p;
    bus(1'b1, 8'(4 * (f / 16)), {16'h0, shadow[f/16]});
  endtask : setp

  task automatic take_ack(input logic [3:0] w);
    ack_wait <= w;
    ack_en <= 1'b1;
    wait_hi(1);
    ack_en <= 1'b0;
    src_pending <= 14'h0;
    trap_req <= 1'b0;
    @(posedge ref_clk);
  endtask : take_ack

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    int f;
    errors = 0;
    compares = 0;
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, trap_req, trap_code, ack_en, ack_wait} = '0;
    hsize = `IPVS_HSIZE_WORD;
    src_pending = 14'h0;
    cpu_level = 4'h0;
    for (int s = 0; s < 14; s++) begin
      f = FMAP[8*s +: 8];
      if (s < 6) begin
        mask[s] = 16'h0;
        rstv[s] = 16'h0;
      end
      mask[f/16][f%16 +: 3] = 3'h7;
      rstv[f/16][f%16 +: 3] = `IPVS_PRIO_RESET;
    end
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int r = 0; r < 6; r++) begin
      bus(1'b0, 8'(4 * r), 32'h0);
      chk("prio reset", rdv, {16'h0, rstv[r]});
      bus(1'b1, 8'(4 * r), 32'hffffffff);
      bus(1'b0, 8'(4 * r), 32'h0);
      chk("prio mask", rdv, {16'h0, mask[r]});
      shadow[r] = 16'h0;
      bus(1'b1, 8'(4 * r), 32'h0);
    end
    bus(1'b1, 8'h28, 32'hffffffff);
    bus(1'b0, 8'h28, 32'h0);
    chk("unmapped", rdv, 32'h0);
    src_pending <= 14'h3fff;
    repeat (3) @(posedge ref_clk);
    chk("disabled req", cpu_irq_req, 1'b0);
    setp(0, 3'h2);
    setp(3, 3'h5);
    setp(7, 3'h5);
    src_pending <= 14'h0089;
    repeat (3) @(posedge ref_clk);
    chk("req level", {cpu_irq_req, cpu_irq_level}, 5'h15);
    chk("req vector", cpu_irq_vector, 7'h03);
    take_ack(4'h3);
    bus(1'b0, `IPVS_OFS_STATUS, 32'h0);
    chk("acked status", rdv, 32'h0503);
    bus(1'b1, `IPVS_OFS_EVT_CLR, 32'h7);
    bus(1'b1, `IPVS_OFS_EVT_EN, 32'h0);
    cpu_level <= 4'h6;
    src_pending <= 14'h0081;
    repeat (3) @(posedge ref_clk);
    chk("blocked req", {cpu_irq_req, irq}, 2'b00);
    bus(1'b0, `IPVS_OFS_STATUS, 32'h0);
    chk("blocked status", rdv, 32'h8503);
    bus(1'b0, `IPVS_OFS_EVT_STAT, 32'h0);
    chk("event status", rdv, 32'h2);
    bus(1'b1, `IPVS_OFS_EVT_EN, 32'h7);
    repeat (2) @(posedge ref_clk);
    chk("irq raised", irq, 1'b1);
    bus(1'b1, `IPVS_OFS_EVT_CLR, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk("irq cleared", irq, 1'b0);
    bus(1'b1, `IPVS_OFS_STATUS, 32'hffffffff);
    bus(1'b0, `IPVS_OFS_STATUS, 32'h0);
    chk("live vector", rdv, 32'ha507);
    setp(13, 3'h6);
    src_pending <= 14'h2081;
    repeat (3) @(posedge ref_clk);
    bus(1'b0, `IPVS_OFS_STATUS, 32'h0);
    chk("live best", rdv, 32'ha50d);
    cpu_level <= 4'hf;
    for (int c = 0; c < 8; c++) begin
      trap_req <= 1'b1;
      trap_code <= 3'(c);
      repeat (2) @(posedge ref_clk);
      chk("trap", {cpu_irq_is_trap, cpu_irq_req, cpu_irq_level}, {2'b11, 4'(8 + c)});
      take_ack(4'(c % 2));
    end
    bus(1'b0, `IPVS_OFS_STATUS, 32'h0);
    chk("trap level", rdv, 32'h2f0d);
    finish_test;
  end
endmodule : ipvs_top_tb
